/* rtl/smart_card_serial_control.sv */
`timescale 1ns/10ps
module smart_card_serial_control
  import sc_pkg::*;
#(
  parameter int BIT_CYCLES  = 32,
  parameter int HALF_CYCLES = 10
)(
  input  wire logic       SYS_CLK,
  input  wire logic       NRST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output      logic [7:0] RDATA,
  input  wire logic       RXD,
  input  wire logic       SCK_IN,
  output      logic       TXD,
  output      logic       SCK_OUT,
  output      logic       SCK_OE
);
  localparam int DW = $clog2(BIT_CYCLES);
  localparam logic [DW-1:0] BIT_LAST = DW'(BIT_CYCLES - 1);
  localparam logic [DW-1:0] HALF_BIT = DW'(BIT_CYCLES / 2);

  logic [7:0]    control_reg;
  logic [7:0]    mode_reg;
  logic [7:0]    card_mode_reg;
  logic [7:0]    tx_buffer;
  logic [7:0]    rx_buffer;
  logic          tde, rbf, ovr, frm, par, tend;
  logic          rxd_m, rxd_s, rxd_d;
  logic          sck_m, sck_s, sck_d;
  logic          tx_busy;
  logic [10:0]   tx_sr;
  logic [3:0]    tx_cnt;
  logic [DW-1:0] tx_div;
  rx_state_t     rx_state;
  logic [10:0]   rx_sr;
  logic [3:0]    rx_cnt;
  logic [DW-1:0] rx_div;
  logic          tx_on, rx_on, sync_mode, stat_wr;
  logic          tx_load, tx_done, rx_sample, rx_last, rx_done;
  logic          rxd_fall, sck_rise;
  logic [10:0]   next_rx_sr;
  logic [7:0]    rx_data;
  clk_sel_if cs ();
  function automatic logic flag_next(logic cur, logic set, logic clr);
    return set | (cur & ~clr);
  endfunction

  assign tx_on     = control_reg[TX_ON_BIT];
  assign rx_on     = control_reg[RX_ON_BIT];
  assign sync_mode = mode_reg[SYNC_BIT];
  assign stat_wr   = WR && (ADDR == STAT_ADDR);

  // two-stage synchronisers, then edge history
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
      rxd_d <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
    end
    else
    begin
      rxd_m <= RXD;
      rxd_s <= rxd_m;
      rxd_d <= rxd_s;
      sck_m <= SCK_IN;
      sck_s <= sck_m;
      sck_d <= sck_s;
    end
  end
  // synchronised edges of the data and link clock lines
  assign rxd_fall = rxd_d && !rxd_s;
  assign sck_rise = sck_s && !sck_d;
  // plain read/write registers
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      control_reg   <= CTRL_RST;
      mode_reg      <= MODE_RST;
      card_mode_reg <= CARD_RST;
      tx_buffer     <= BUF_RST;
    end
    else if (WR)
    begin
      if (ADDR == CTRL_ADDR)
        control_reg <= WDATA;
      else if (ADDR == MODE_ADDR)
        mode_reg <= WDATA;
      else if (ADDR == CARD_ADDR)
        card_mode_reg <= WDATA;
      else if (ADDR == TXBUF_ADDR)
        tx_buffer <= WDATA;
    end
  end

  // clock pin selection handed to the generator
  assign cs.sel   = control_reg[SEL_HI_BIT:SEL_LO_BIT];
  assign cs.guard = mode_reg[GUARD_BIT];
  assign cs.card  = card_mode_reg[CARD_SEL_BIT];
  assign SCK_OUT  = cs.pin_out;
  assign SCK_OE   = cs.pin_oe;
  sck_gen #(.HALF_CYCLES(HALF_CYCLES)) u_sck (
    .clk  (SYS_CLK),
    .nrst (NRST),
    .bus  (cs)
  );
  // transmit start once enabled, not busy and empty flag cleared
  assign tx_load = tx_on && !tde && !tx_busy;
  assign tx_done = tx_busy && (tx_div == BIT_LAST) && (tx_cnt == FRAME_LAST);
  // transmit shifter: start, data lsb first, even parity, stop
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST || !tx_on)
    begin
      tx_busy <= 1'b0;
      tx_sr   <= '1;
      tx_cnt  <= '0;
      tx_div  <= '0;
      TXD     <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_sr   <= {1'b1, ^tx_buffer, tx_buffer, 1'b0};
      tx_busy <= 1'b1;
      tx_cnt  <= '0;
      tx_div  <= '0;
      TXD     <= 1'b1;
    end
    else
    begin
      TXD <= tx_busy ? tx_sr[0] : 1'b1;
      if (tx_busy)
      begin
        tx_div <= (tx_div == BIT_LAST) ? '0 : tx_div + 1'b1;
        if (tx_div == BIT_LAST)
        begin
          tx_sr   <= {1'b1, tx_sr[10:1]};
          tx_cnt  <= tx_cnt + 1'b1;
          tx_busy <= !tx_done;
        end
      end
    end
  end
  // receive sampling
  assign rx_sample  = (rx_state == RX_SHIFT) &&
                      (sync_mode ? sck_rise : (rx_div == BIT_LAST));
  assign rx_last    = (rx_cnt == (sync_mode ? DATA_LAST : FRAME_LAST));
  assign rx_done    = rx_on && rx_sample && rx_last;
  assign next_rx_sr = {rxd_s, rx_sr[10:1]};
  assign rx_data    = sync_mode ? next_rx_sr[10:3] : next_rx_sr[8:1];
  // receive sequencer
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      rx_state <= RX_IDLE;
      rx_sr    <= '1;
      rx_cnt   <= '0;
      rx_div   <= '0;
    end
    else if (!rx_on)
      rx_state <= RX_IDLE;
    else
      case (rx_state)
        RX_IDLE:
        begin
          rx_cnt <= '0;
          if (sync_mode)
            rx_state <= RX_SHIFT;
          else if (rxd_fall)
          begin
            rx_state <= RX_SHIFT;
            rx_div   <= HALF_BIT;
          end
        end
        RX_SHIFT:
        begin
          rx_div <= (rx_div == BIT_LAST) ? '0 : rx_div + 1'b1;
          if (rx_sample)
          begin
            rx_sr  <= next_rx_sr;
            rx_cnt <= rx_cnt + 1'b1;
            if (rx_last)
              rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
  end

  // status flags: hardware set wins, software may only clear
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      tde       <= 1'b1;
      tend      <= 1'b1;
      rbf       <= 1'b0;
      ovr       <= 1'b0;
      frm       <= 1'b0;
      par       <= 1'b0;
      rx_buffer <= BUF_RST;
    end
    else
    begin
      tde  <= flag_next(tde, !tx_on || tx_load, stat_wr && !WDATA[TDE_BIT]);
      tend <= flag_next(tend, tx_done && tde, stat_wr && !WDATA[TDE_BIT]);
      // rx_on clearing touches none of these
      rbf <= flag_next(rbf, rx_done && !rbf, stat_wr && !WDATA[RBF_BIT]);
      ovr <= flag_next(ovr, rx_done && rbf, stat_wr && !WDATA[OVR_BIT]);
      frm <= flag_next(frm, rx_done && !sync_mode && !next_rx_sr[10],
                       stat_wr && !WDATA[FRM_BIT]);
      par <= flag_next(par, rx_done && !sync_mode && (^next_rx_sr[9:1]),
                       stat_wr && !WDATA[PAR_BIT]);
      if (rx_done && !rbf)
        rx_buffer <= rx_data;
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST || !RD)
      RDATA <= ZERO8;
    else if (ADDR == CTRL_ADDR)
      RDATA <= control_reg;
    else if (ADDR == STAT_ADDR)
      RDATA <= {tde, rbf, ovr, frm, par, tend, 2'b00};
    else if (ADDR == MODE_ADDR)
      RDATA <= mode_reg;
    else if (ADDR == CARD_ADDR)
      RDATA <= card_mode_reg;
    else if (ADDR == TXBUF_ADDR)
      RDATA <= tx_buffer;
    else if (ADDR == RXBUF_ADDR)
      RDATA <= rx_buffer;
    else
      RDATA <= ZERO8;
  end
  // load conditions; clearing tx_on may cut the start bit short
  sequence s_tx_ready;
    tx_on && !tde && !tx_busy;
  endsequence
  chk_tx_start: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    s_tx_ready |=> tx_busy && tde ##1 (!TXD || !tx_on))
    else $error("transmission did not start");
  chk_tde_held: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    !tx_on |=> tde && !tx_busy)
    else $error("empty flag not held while transmit off");
  chk_rx_begin: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (rx_on && !sync_mode && rx_state == RX_IDLE && rxd_fall)
      |=> (rx_state == RX_SHIFT))
    else $error("start bit did not begin reception");
  chk_rx_flags_keep: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (!rx_on && !stat_wr) |=> $stable({rbf, frm, par, ovr}))
    else $error("receive flags changed with reception off");
  chk_write_no_set: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (stat_wr && !rbf && !rx_done) |=> !rbf)
    else $error("software write set a status flag");
  chk_zero_clears: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (stat_wr && !WDATA[RBF_BIT] && !rx_done) |=> !rbf)
    else $error("written zero did not clear flag");
  chk_read_timing: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (RD && ADDR == CTRL_ADDR) |=> (RDATA == $past(control_reg)))
    else $error("read data wrong in cycle after strobe");
endmodule

/* rtl/sc_pkg.sv */
package sc_pkg;
  // register indices on the plain register port
  localparam logic [2:0] CTRL_ADDR  = 3'h0;
  localparam logic [2:0] STAT_ADDR  = 3'h1;
  localparam logic [2:0] MODE_ADDR  = 3'h2;
  localparam logic [2:0] CARD_ADDR  = 3'h3;
  localparam logic [2:0] TXBUF_ADDR = 3'h4;
  localparam logic [2:0] RXBUF_ADDR = 3'h5;
  // control_reg fields
  localparam int TX_ON_BIT      = 5;
  localparam int RX_ON_BIT      = 4;
  localparam int ADDR_IRQ_BIT   = 3;
  localparam int TXDONE_IRQ_BIT = 2;
  localparam int SEL_HI_BIT     = 1;
  localparam int SEL_LO_BIT     = 0;
  // status_reg fields
  localparam int TDE_BIT  = 7;
  localparam int RBF_BIT  = 6;
  localparam int OVR_BIT  = 5;
  localparam int FRM_BIT  = 4;
  localparam int PAR_BIT  = 3;
  localparam int TEND_BIT = 2;
  // mode_reg and card_mode_reg fields
  localparam int SYNC_BIT     = 7;
  localparam int GUARD_BIT    = 6;
  localparam int CARD_SEL_BIT = 0;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CARD_RST = 8'h00;
  localparam logic [7:0] BUF_RST  = 8'h00;
  localparam logic [7:0] ZERO8    = 8'h00;
  // frame: start, 8 data, parity, stop
  localparam logic [3:0] FRAME_LAST = 4'ha;
  localparam logic [3:0] DATA_LAST  = 4'h7;
  // clock pin selection codes
  localparam logic [1:0] SEL_OFF  = 2'b00;
  localparam logic [1:0] SEL_CLK  = 2'b01;
  typedef enum logic [1:0] {
    PIN_PORT = 2'b00,
    PIN_LOW  = 2'b01,
    PIN_HIGH = 2'b10,
    PIN_CLK  = 2'b11
  } pin_mode_t;
  typedef enum logic [0:0] {
    RX_IDLE  = 1'b0,
    RX_SHIFT = 1'b1
  } rx_state_t;
endpackage

/* rtl/clk_sel_if.sv */
`timescale 1ns/10ps
interface clk_sel_if;
  logic [1:0] sel;
  logic       guard;
  logic       card;
  logic       pin_out;
  logic       pin_oe;
  modport ctrl (output sel, output guard, output card,
                input pin_out, input pin_oe);
  modport gen (input sel, input guard, input card,
               output pin_out, output pin_oe);
endinterface

/* rtl/sck_gen.sv */
`timescale 1ns/10ps
module sck_gen
  import sc_pkg::*;
#(
  parameter int HALF_CYCLES = 10
)(
  input wire logic   clk,
  input wire logic   nrst,
  clk_sel_if.gen     bus
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYCLES - 1);
  localparam int SWITCH_LIM = 2 * HALF_CYCLES + 2;

  logic [CW-1:0] cnt;
  logic          level;
  pin_mode_t     mode;
  pin_mode_t     req;
  pin_mode_t     eff;
  logic          wrap;
  logic          fall;
  logic          next_level;

  // decode of the requested pin function
  always_comb
  begin
    if (bus.card && bus.guard)
      req = bus.sel[0] ? PIN_CLK : (bus.sel[1] ? PIN_HIGH : PIN_LOW);
    else
      req = (bus.sel == SEL_CLK) ? PIN_CLK : PIN_PORT;
  end

  assign wrap       = (cnt == HALF_LAST);
  assign fall       = wrap && level;
  assign next_level = wrap ? ~level : level;
  // new selection only at a falling edge, so no short pulse
  assign eff        = fall ? req : mode;

  // free-running divided clock
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt   <= '0;
      level <= 1'b0;
    end
    else
    begin
      cnt   <= wrap ? '0 : cnt + 1'b1;
      level <= next_level;
    end
  end

  // applied pin function, reread during operation
  always_ff @(posedge clk)
  begin
    if (!nrst)
      mode <= PIN_PORT;
    else if (fall)
      mode <= req;
  end

  // pin drive
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bus.pin_out <= 1'b0;
      bus.pin_oe  <= 1'b0;
    end
    else
    begin
      bus.pin_out <= (eff == PIN_CLK) ? next_level : (eff == PIN_HIGH);
      bus.pin_oe  <= (eff != PIN_PORT);
    end
  end

  chk_mode_at_fall: assert property (
    @(posedge clk) disable iff (!nrst)
    $changed(mode) |-> $past(fall))
    else $error("pin function changed away from a falling edge");

  chk_fixed_low: assert property (
    @(posedge clk) disable iff (!nrst)
    (mode == PIN_LOW && !fall) |=> (bus.pin_oe && !bus.pin_out))
    else $error("fixed low selection not driving low");

  chk_port_release: assert property (
    @(posedge clk) disable iff (!nrst)
    (mode == PIN_PORT && !fall) |=> !bus.pin_oe)
    else $error("pin driven while released to port use");

  chk_switch_bound: assert property (
    @(posedge clk) disable iff (!nrst)
    (req != mode) ##1 $stable(req) [*1] |-> ##[0:SWITCH_LIM] (mode == req))
    else $error("clock pin selection not applied in time");
endmodule

/* tb/card_model.sv */
`timescale 1ns/10ps
module card_model #(
  parameter int BIT_NS = 32
)(
  input  wire logic       go,
  input  wire logic       sync,
  input  wire logic [7:0] byte_in,
  output      logic       rxd,
  output      logic       sck
);
  logic [10:0] frame;
  // line idles at its pull-up level, clock stands low
  initial
  begin
    rxd = 1'b1;
    sck = 1'b0;
  end
  // one frame per go pulse: clocked bits or start/data/parity/stop
  always @(posedge go)
  begin
    frame = {1'b1, ^byte_in, byte_in, 1'b0};
    if (sync)
      for (int i = 0; i < 8; i++)
      begin
        rxd = byte_in[i];
        #40 sck = 1'b1;
        #40 sck = 1'b0;
      end
    else
      for (int i = 0; i < 11; i++)
      begin
        rxd = frame[i];
        #(BIT_NS);
      end
    rxd = 1'b1;
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench
  import sc_pkg::*;
;
  localparam int BITC = 8;
  localparam int HALF = 2;
  logic       sys_clk, nrst, wr, rd, rxd, sck_in, txd, sck_out, sck_oe;
  logic       go, sync;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, cbyte, v;
  logic [9:0] f;
  logic [5:0] tbl [8];
  int         num_errors, checks_done, n;

  smart_card_serial_control #(.BIT_CYCLES(BITC), .HALF_CYCLES(HALF)) dut_u (
    .SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .RXD(rxd), .SCK_IN(sck_in), .TXD(txd),
    .SCK_OUT(sck_out), .SCK_OE(sck_oe));
  card_model #(.BIT_NS(BITC * 4)) card_u (
    .go(go), .sync(sync), .byte_in(cbyte), .rxd(rxd), .sck(sck_in));

  // 250 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    tick();
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick();
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    tick();
    addr <= a;
    rd <= 1'b1;
    tick();
    rd <= 1'b0;
    d = rdata;
  endtask
  // set mode, card and selection, then classify what the pin does
  task automatic pin_chk(input logic c, g, input logic [1:0] s,
                         input logic [1:0] exp);
    int oe_n, tog;
    logic last;
    wr_reg(MODE_ADDR, {1'b0, g, 6'h00});
    wr_reg(CARD_ADDR, {7'h00, c});
    wr_reg(CTRL_ADDR, {6'h00, s});
    repeat (2 * HALF + 2) tick();
    oe_n = 0;
    tog = 0;
    last = sck_out;
    repeat (4 * HALF)
    begin
      tick();
      oe_n += int'(sck_oe === 1'b1);
      tog += int'(sck_out !== last);
      last = sck_out;
    end
    v[1:0] = (oe_n == 0) ? PIN_PORT : (tog > 0) ? PIN_CLK :
             last ? PIN_HIGH : PIN_LOW;
    chk("sck pin", {6'h00, exp}, {6'h00, v[1:0]});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    nrst = 1'b0;
    {addr, wdata, wr, rd, go, sync, cbyte} = '0;
    tbl = '{6'b000000, 6'b000111, 6'b010000, 6'b101000,
            6'b110001, 6'b110111, 6'b111010, 6'b111111};
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_reg(STAT_ADDR, v);
    chk("status reset", 8'h84, v);
    wr_reg(STAT_ADDR, 8'hff);
    rd_reg(STAT_ADDR, v);
    chk("status write one", 8'h84, v);
    wr_reg(3'h6, 8'h5a);
    rd_reg(3'h6, v);
    chk("unmapped", 8'h00, v);
    wr_reg(STAT_ADDR, 8'h7f);
    rd_reg(STAT_ADDR, v);
    chk("empty with tx off", 8'h80, v & 8'h80);
    // format first, then enables with both irq enables zero
    wr_reg(MODE_ADDR, MODE_RST);
    wr_reg(CARD_ADDR, 8'h01);
    wr_reg(CTRL_ADDR, 8'h30);
    wr_reg(TXBUF_ADDR, 8'ha5);
    wr_reg(STAT_ADDR, 8'h7f);
    n = 0;
    while (txd !== 1'b0 && n < 100)
    begin
      tick();
      n++;
    end
    repeat (BITC / 2) tick();
    for (int i = 0; i < 10; i++)
    begin
      repeat (BITC) tick();
      f[i] = txd;
    end
    chk("tx data", 8'ha5, f[7:0]);
    chk("tx parity stop", 8'h02, {6'h00, f[9:8]});
    // asynchronous receive, then disable keeps flags
    cbyte <= 8'h3c;
    go <= 1'b1;
    tick();
    go <= 1'b0;
    repeat (11 * BITC + 20) tick();
    rd_reg(STAT_ADDR, v);
    chk("rx full", 8'h40, v & 8'h78);
    rd_reg(RXBUF_ADDR, v);
    chk("rx async byte", 8'h3c, v);
    // second frame while still full: overrun, first byte kept
    cbyte <= 8'hc3;
    go <= 1'b1;
    tick();
    go <= 1'b0;
    repeat (11 * BITC + 20) tick();
    rd_reg(RXBUF_ADDR, v);
    chk("rx byte on overrun", 8'h3c, v);
    wr_reg(CTRL_ADDR, 8'h00);
    rd_reg(STAT_ADDR, v);
    chk("rx flags kept", 8'he0, v & 8'hf8);
    wr_reg(STAT_ADDR, 8'hbf);
    rd_reg(STAT_ADDR, v);
    chk("rx full cleared", 8'h00, v & 8'h40);
    // clocked synchronous receive on the link clock
    wr_reg(MODE_ADDR, 8'h80);
    wr_reg(CTRL_ADDR, 8'h10);
    cbyte <= 8'h96;
    sync <= 1'b1;
    go <= 1'b1;
    tick();
    go <= 1'b0;
    repeat (8 * 20 + 20) tick();
    rd_reg(RXBUF_ADDR, v);
    chk("rx sync byte", 8'h96, v);
    // enables off before mode writes, then pin modes switched live
    wr_reg(CTRL_ADDR, 8'h00);
    for (int i = 0; i < 8; i++)
      pin_chk(tbl[i][5], tbl[i][4], tbl[i][3:2], tbl[i][1:0]);
    tally_and_finish();
  end
endmodule
